// ---- sleep_ctrl_pkg.sv ----
package sleep_ctrl_pkg;

  // clock rate of the block's own clock
  localparam int CLOCK_MHZ = 250;
  // least reset pulse the controller must apply, in nanoseconds
  localparam int RESET_MIN_NS = 15000;
  // least reset pulse in clock cycles, rounded up
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLOCK_MHZ + 999) / 1000;
  // width of the reset pulse counter
  localparam int RST_CNT_W = 12;
  // main clock edges per master clock output period
  localparam int MCLK_DIV = 4;
  // divider counter width
  localparam int DIV_W = 2;
  // reset value of the unusable data flag: raised by reset
  localparam logic FLAG_RST = 1'h1;
  // reset value of the subband direction: play, device to codec
  localparam logic DIR_RST = 1'h1;

  // operating modes
  typedef enum logic [1:0] {
    play_all_mode = 2'h0,
    record_all_mode = 2'h1,
    play_main_record_aux_mode = 2'h2
  } mode_t;

  // sequencer states
  typedef enum logic [1:0] {
    st_reset = 2'h0,
    st_run = 2'h1,
    st_sleep = 2'h2,
    st_wake = 2'h3
  } state_t;

endpackage

// ---- level_sync.sv ----
`timescale 1ns/1ps
// two flip-flop synchroniser for asynchronous levels
module level_sync #(
  parameter int W = 3
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // packed state: first and second stage
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t q_r;
  sync_state_t q_nxt;

  // first stage feeds only the second stage
  always_comb begin
    q_nxt.meta = async_in;
    q_nxt.stable = q_r.meta;
  end

  // registers clear to zero under reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sync_out = q_r.stable;

endmodule

// ---- tape_formatter_reset_sleep_mode_ctrl.sv ----
`timescale 1ns/1ps
// Behaviour
// - reset reinitialises state, selects play all mode
// - three modes: play all, record all, mixed
// - power down request high means sleep, idle
// - master clock timing derived from the main clock input
// - master clock out is main clock over four
// - play decodes 10 to 8, record encodes 8 to 10
// - two level error correction decode or encode
// - play recovers all tape channels into memory
// - unusable flag on reset, record to play mode change, resync
// - subband direction 1 on play, 0 on record
module tape_formatter_reset_sleep_mode_ctrl (
  input wire logic clock,
  input wire logic arst_n,
  // active high device reset pin from the controller
  input wire logic reset_in,
  // active high sleep request pin
  input wire logic power_down_request,
  // nominal 24.576 MHz clock pin, sampled as a level
  input wire logic main_clock_in,
  // requested operating mode, same clock domain
  input wire logic [1:0] mode_request,
  // one cycle strobe that loads mode_request
  input wire logic mode_request_valid,
  // one cycle pulse: datapath must resynchronise to tape
  input wire logic resync_event,
  // one cycle pulse: datapath has good data again
  input wire logic data_valid_event,
  // master clock output, main clock divided by four
  output logic master_clock_out,
  // current operating mode
  output logic [1:0] operating_mode,
  // high when main, system_info_data and aux data are not usable
  output logic unusable_data_flag,
  // 1 device to codec (play), 0 codec to device (record)
  output logic subband_direction,
  // main channel play path enable: recovery, demod, decode
  output logic main_play_enable,
  // main channel record path enable: encode, modulation
  output logic main_record_enable,
  // aux channel play path enable
  output logic aux_play_enable,
  // aux channel record path enable
  output logic aux_record_enable,
  // high while the device sits in sleep
  output logic sleep_active,
  // high while the device is held in reset
  output logic device_in_reset,
  // last reset pulse that ended in run was shorter than the least duration
  output logic short_reset_seen
);

  // packed state of the whole block
  typedef struct packed {
    sleep_ctrl_pkg::state_t state;
    sleep_ctrl_pkg::mode_t mode;
    logic clk_prev;
    logic [sleep_ctrl_pkg::DIV_W-1:0] div;
    logic mclk;
    logic flag;
    logic dir;
    logic main_play;
    logic main_rec;
    logic aux_play;
    logic aux_rec;
    logic [sleep_ctrl_pkg::RST_CNT_W-1:0] rst_cnt;
    logic short_rst;
    // registered copy of the sleep state, drives its pin directly
    logic asleep;
    // registered copy of the reset state, drives its pin directly
    logic in_rst;
  } ctrl_state_t;

  // reset value of every field
  localparam ctrl_state_t CTRL_RST = '{
    state: sleep_ctrl_pkg::st_reset,
    mode: sleep_ctrl_pkg::play_all_mode,
    clk_prev: 1'h0,
    div: '0,
    mclk: 1'h0,
    flag: sleep_ctrl_pkg::FLAG_RST,
    dir: sleep_ctrl_pkg::DIR_RST,
    main_play: 1'h0,
    main_rec: 1'h0,
    aux_play: 1'h0,
    aux_rec: 1'h0,
    rst_cnt: '0,
    short_rst: 1'h0,
    asleep: 1'h0,
    in_rst: 1'h1
  };

  localparam logic [sleep_ctrl_pkg::RST_CNT_W-1:0] RST_MIN =
    sleep_ctrl_pkg::RST_CNT_W'(sleep_ctrl_pkg::RESET_MIN_CYC);

  ctrl_state_t q_r;
  ctrl_state_t q_nxt;
  logic [2:0] pins_sync;
  logic rst_s;
  logic pdr_s;
  logic clk_s;
  logic clk_rise;

  // all three pins are asynchronous to clock
  level_sync #(.W(3)) u_pin_sync (
    .clock(clock),
    .arst_n(arst_n),
    .async_in({main_clock_in, power_down_request, reset_in}),
    .sync_out(pins_sync)
  );

  assign rst_s = pins_sync[0];
  assign pdr_s = pins_sync[1];
  assign clk_s = pins_sync[2];
  // edge of the sampled main clock; a static clock gives none
  assign clk_rise = clk_s & ~q_r.clk_prev;

  // legality check on a requested mode code
  function automatic logic mode_legal(input logic [1:0] m);
    mode_legal = (m == sleep_ctrl_pkg::play_all_mode) ||
                 (m == sleep_ctrl_pkg::record_all_mode) ||
                 (m == sleep_ctrl_pkg::play_main_record_aux_mode);
  endfunction

  // next state of the whole block
  always_comb begin
    q_nxt = q_r;
    q_nxt.clk_prev = clk_s;

    // sequencer
    case (q_r.state)
      sleep_ctrl_pkg::st_reset: begin
        // hold default mode while reset is high
        q_nxt.mode = sleep_ctrl_pkg::play_all_mode;
        q_nxt.div = '0;
        q_nxt.mclk = 1'h0;
        if (pdr_s) begin
          // reset level no longer matters once asleep
          q_nxt.state = sleep_ctrl_pkg::st_sleep;
        end else if (!rst_s) begin
          q_nxt.state = sleep_ctrl_pkg::st_run;
          // flag a pulse the controller cut short; a power-on release
          // with no pulse counted is not a short pulse
          q_nxt.short_rst = (q_r.rst_cnt != '0) &&
                            (q_r.rst_cnt < RST_MIN);
        end
      end
      sleep_ctrl_pkg::st_run: begin
        if (pdr_s) begin
          q_nxt.state = sleep_ctrl_pkg::st_sleep;
        end else if (rst_s) begin
          q_nxt.state = sleep_ctrl_pkg::st_reset;
        end else if (mode_request_valid && mode_legal(mode_request)) begin
          q_nxt.mode = sleep_ctrl_pkg::mode_t'(mode_request);
        end
      end
      sleep_ctrl_pkg::st_sleep: begin
        // frozen divider: no activity while asleep
        q_nxt.div = '0;
        q_nxt.mclk = 1'h0;
        if (!pdr_s) begin
          q_nxt.state = sleep_ctrl_pkg::st_wake;
        end
      end
      sleep_ctrl_pkg::st_wake: begin
        // nothing runs until the wake reset pulse arrives
        if (pdr_s) begin
          q_nxt.state = sleep_ctrl_pkg::st_sleep;
        end else if (rst_s) begin
          q_nxt.state = sleep_ctrl_pkg::st_reset;
        end
      end
      default: begin
        q_nxt.state = sleep_ctrl_pkg::st_reset;
      end
    endcase

    // reset pulse length, counted in clock cycles, saturating
    if (!rst_s) begin
      q_nxt.rst_cnt = '0;
    end else if (q_r.rst_cnt != '1) begin
      q_nxt.rst_cnt = q_r.rst_cnt + 1'h1;
    end

    // divide-by-four master clock: toggle every second edge
    if (q_r.state == sleep_ctrl_pkg::st_run && clk_rise) begin
      q_nxt.div = q_r.div + 1'h1;
      if (q_r.div[0]) begin
        q_nxt.mclk = ~q_r.mclk;
      end
    end

    // unusable flag: clear first so that any set wins
    if (data_valid_event && q_r.state == sleep_ctrl_pkg::st_run) begin
      q_nxt.flag = 1'h0;
    end
    if (q_r.state != sleep_ctrl_pkg::st_run) begin
      q_nxt.flag = 1'h1;
    end
    if (resync_event) begin
      q_nxt.flag = 1'h1;
    end
    if (q_r.mode == sleep_ctrl_pkg::record_all_mode &&
        q_nxt.mode == sleep_ctrl_pkg::play_all_mode) begin
      q_nxt.flag = 1'h1;
    end

    // direction and path enables follow the next mode
    q_nxt.dir = (q_nxt.mode != sleep_ctrl_pkg::record_all_mode);
    q_nxt.main_play = (q_nxt.state == sleep_ctrl_pkg::st_run) &&
                      q_nxt.dir;
    q_nxt.main_rec = (q_nxt.state == sleep_ctrl_pkg::st_run) &&
                     !q_nxt.dir;
    q_nxt.aux_play = (q_nxt.state == sleep_ctrl_pkg::st_run) &&
      (q_nxt.mode == sleep_ctrl_pkg::play_all_mode);
    q_nxt.aux_rec = (q_nxt.state == sleep_ctrl_pkg::st_run) &&
      (q_nxt.mode != sleep_ctrl_pkg::play_all_mode);
    // status pins registered so no state decode sits behind them
    q_nxt.asleep = (q_nxt.state == sleep_ctrl_pkg::st_sleep);
    q_nxt.in_rst = (q_nxt.state == sleep_ctrl_pkg::st_reset);
  end

  // single state register, constant under reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= CTRL_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // every output comes straight from a field of q_r
  assign master_clock_out = q_r.mclk;
  assign operating_mode = q_r.mode;
  assign unusable_data_flag = q_r.flag;
  assign subband_direction = q_r.dir;
  assign main_play_enable = q_r.main_play;
  assign main_record_enable = q_r.main_rec;
  assign aux_play_enable = q_r.aux_play;
  assign aux_record_enable = q_r.aux_rec;
  assign sleep_active = q_r.asleep;
  assign device_in_reset = q_r.in_rst;
  assign short_reset_seen = q_r.short_rst;

endmodule

// ---- tape_formatter_reset_sleep_mode_ctrl_properties.sv ----
`timescale 1ns/1ps
// watches the sequencer from its ports alone
module sleep_ctrl_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reset_in,
  input wire logic power_down_request,
  input wire logic main_clock_in,
  input wire logic [1:0] mode_request,
  input wire logic mode_request_valid,
  input wire logic resync_event,
  input wire logic data_valid_event,
  input wire logic master_clock_out,
  input wire logic [1:0] operating_mode,
  input wire logic unusable_data_flag,
  input wire logic subband_direction,
  input wire logic main_play_enable,
  input wire logic main_record_enable,
  input wire logic aux_play_enable,
  input wire logic aux_record_enable,
  input wire logic sleep_active,
  input wire logic device_in_reset,
  input wire logic short_reset_seen
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // a main path is enabled only while running
  wire run = main_play_enable || main_record_enable;
  // nothing pending on the pins, so a load cannot race a reset
  wire quiet = !reset_in && !power_down_request;
  wire load = mode_request_valid && mode_request != 2'h3;
  logic mq_r;
  logic seen_r;
  logic [7:0] hc_r;
  // cycles between master clock toggles; first toggle only arms it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mq_r <= 1'h0;
      seen_r <= 1'h0;
      hc_r <= 8'h00;
    end else begin
      mq_r <= master_clock_out;
      hc_r <= (master_clock_out != mq_r) ? 8'h00 : hc_r + 8'h01;
      seen_r <= run && (seen_r || master_clock_out != mq_r);
    end
  end
  reset_hold_a: assert property (
    (reset_in && !power_down_request)[*7] |-> device_in_reset)
    else $error("reset pin not obeyed");
  reset_value_a: assert property (
    device_in_reset[*2] |-> operating_mode == 2'h0 && !run &&
    !master_clock_out)
    else $error("reset state outputs wrong");
  mode_load_a: assert property (
    quiet[*3] ##0 (load && run) |=> operating_mode == $past(mode_request))
    else $error("mode not loaded");
  path_enable_a: assert property (
    run |-> main_record_enable == (operating_mode == 2'h1) &&
    main_play_enable != main_record_enable &&
    aux_play_enable == (operating_mode == 2'h0) &&
    aux_record_enable != aux_play_enable)
    else $error("path enables wrong");
  direction_a: assert property (
    run |-> subband_direction == (operating_mode != 2'h1))
    else $error("direction wrong");
  sleep_entry_a: assert property (
    power_down_request[*6] |-> sleep_active && !run && !master_clock_out &&
    unusable_data_flag)
    else $error("sleep not entered");
  mclk_ratio_a: assert property (
    seen_r && run && master_clock_out != mq_r |-> hc_r == 8'h13)
    else $error("master clock period wrong");
  flag_resync_a: assert property (
    resync_event |=> unusable_data_flag)
    else $error("flag not raised by resync");
  flag_mode_a: assert property (
    quiet[*3] ##0 (load && run && operating_mode == 2'h1 &&
    mode_request == 2'h0) |=> unusable_data_flag)
    else $error("flag not raised by mode change");
  sync_lag_a: assert property (
    run && $rose(reset_in) |=> !device_in_reset)
    else $error("reset acted on unsynchronised");
  cover property ($rose(sleep_active));
  cover property (load && run);
  cover property ($rose(short_reset_seen));
endmodule
bind tape_formatter_reset_sleep_mode_ctrl sleep_ctrl_checker
  sleep_ctrl_checker_i (.*);

// ---- ctrl_model.sv ----
`timescale 1ns/1ps
// controller side: reset and sleep pins plus the main clock
module ctrl_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic go_reset,
  input wire logic short_pulse,
  input wire logic go_sleep,
  input wire logic clk_run,
  output logic reset_in,
  output logic power_down_request,
  output logic main_clock_in
);
  localparam int FULL = sleep_ctrl_pkg::RESET_MIN_CYC;
  int div;
  int cnt;
  // main clock of ten fast cycles, held at its level when stopped
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reset_in <= 1'h0;
      power_down_request <= 1'h0;
      main_clock_in <= 1'h0;
      div <= 0;
      cnt <= 0;
    end else begin
      div <= (div == 4) ? 0 : div + 1;
      if (clk_run && div == 4) begin
        main_clock_in <= !main_clock_in;
      end
      if (go_reset) begin
        reset_in <= 1'h1;
        cnt <= short_pulse ? 10 : FULL;
      end else if (go_sleep && !reset_in && !power_down_request) begin
        reset_in <= 1'h1;
        cnt <= FULL;
      end else if (power_down_request && !go_sleep) begin
        power_down_request <= 1'h0;
        reset_in <= 1'h1;
        cnt <= FULL;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end else if (go_sleep) begin
        // reset is dropped once asleep, since it no longer matters
        power_down_request <= 1'h1;
        reset_in <= !power_down_request;
      end else begin
        reset_in <= 1'h0;
      end
    end
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
// drives the sequencer, notes expected status, checks in order
module testbench;
  logic clock, arst_n, go_reset, short_pulse, go_sleep, clk_run;
  logic reset_in, power_down_request, main_clock_in;
  logic [1:0] mode_request, operating_mode, em, c;
  logic mode_request_valid, resync_event, data_valid_event, ef;
  logic master_clock_out, unusable_data_flag, subband_direction;
  logic main_play_enable, main_record_enable, aux_play_enable;
  logic aux_record_enable, sleep_active, device_in_reset;
  logic short_reset_seen, sample_req;
  logic [6:0] notes[$];
  int num_errors, comparisons, cycles;
  tape_formatter_reset_sleep_mode_ctrl
    tape_formatter_reset_sleep_mode_ctrl_i (.*);
  ctrl_model ctrl_model_i (.*);
  wire [6:0] obs = {operating_mode, unusable_data_flag, subband_direction,
    sleep_active, device_in_reset, short_reset_seen};
  initial begin
    clock = 1'h0;
    forever #2 clock = !clock;
  end
  // monitor: oldest note against the settled status
  always @(posedge sample_req) begin
    comparisons++;
    if (obs !== notes[0]) begin
      num_errors++;
      $display("[ERR] status expected %h seen %h", notes[0], obs);
    end
    notes.delete(0);
  end
  task automatic note(input logic [6:0] e);
    notes.push_back(e);
    sample_req = 1'h1;
    #1 sample_req = 1'h0;
  endtask
  // one-cycle strobes, then time for the answer to land
  task automatic drive(input logic [1:0] m, input logic v, r, d);
    @(posedge clock);
    {mode_request, mode_request_valid, resync_event, data_valid_event} <=
      {m, v, r, d};
    @(posedge clock);
    {mode_request_valid, resync_event, data_valid_event} <= 3'h0;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic ctl(input logic r, s, z);
    @(posedge clock);
    {go_reset, short_pulse, go_sleep} <= {r, s, z};
    @(posedge clock);
    go_reset <= 1'h0;
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'h1 && n < 9000) begin
      @(posedge clock);
      n++;
    end
    #1;
  endtask
  task summarize;
    $display("compared %0d, mismatched %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, about five times the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    {arst_n, go_reset, short_pulse, go_sleep, clk_run} = 5'h01;
    {mode_request, mode_request_valid, resync_event, data_valid_event} = 5'h00;
    sample_req = 1'h0;
    void'($urandom(13593));
    repeat (20) @(posedge clock);
    arst_n <= 1'h1;
    repeat (8) @(posedge clock);
    #1;
    note(7'h18);
    $display("reset defaults done");
    drive(2'h0, 1'h0, 1'h0, 1'h1);
    note(7'h08);
    {em, ef} = 3'h0;
    // codes 1,0,2,3 first, so record to play and the unused code occur
    for (int k = 0; k < 8; k++) begin
      c = (k < 4) ? 2'(8'hE1 >> (2 * k)) : 2'($urandom);
      drive(c, 1'h1, 1'h0, 1'h0);
      if (c != 2'h3) begin
        ef = ef || (em == 2'h1 && c == 2'h0);
        em = c;
      end
      note({em, ef, em != 2'h1, 3'h0});
    end
    $display("modes done");
    drive(em, 1'h0, 1'h1, 1'h1);
    note({em, 1'h1, em != 2'h1, 3'h0});
    drive(em, 1'h0, 1'h0, 1'h1);
    note({em, 1'h0, em != 2'h1, 3'h0});
    $display("flag done");
    ctl(1'h1, 1'h1, 1'h0);
    wait_hi(device_in_reset);
    note(7'h1A);
    wait_hi(main_play_enable);
    note(7'h19);
    $display("short reset done");
    ctl(1'h0, 1'h0, 1'h1);
    wait_hi(sleep_active);
    @(posedge clock);
    clk_run <= 1'h0;
    drive(2'h1, 1'h1, 1'h0, 1'h0);
    note(7'h1D);
    repeat (50) @(posedge clock);
    ctl(1'h0, 1'h0, 1'h0);
    clk_run <= 1'h1;
    wait_hi(device_in_reset);
    wait_hi(main_play_enable);
    note(7'h18);
    $display("sleep done");
    summarize();
  end
endmodule
